// [src/sdp_port.sv]
`timescale 1ns/10ps
// Summary of operation
// - During SDRAM accesses the three shared strobe pins act as column strobe, write enable and row strobe.
// - The direct transfer strobe fires for a read only in direct mode with the source option set.
// - The direct transfer strobe fires for a write only in direct mode with the destination option set.
// - A direct transfer read never captures the data bus; the peripheral takes the data.
// - A direct transfer write keeps the data bus undriven throughout.
// - The read latency field delays the strobe by 0 to 3 memory clocks after the read data phase.
// - The write latency field delays the strobe by 0 to 3 memory clocks after the write data phase.
// - Only the wide port drives the SDRAM clock enable; the narrow port has none.
// - Both ports can issue activate, single bank deactivate and all bank deactivate commands.
// - Self-refresh entry and exit exist only on the wide port.
module sdp_port #(
  parameter bit WIDE_PORT = 1'b1,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ADDR_W = 13,
  parameter int unsigned BANK_W = 2,
  parameter int unsigned CAS_LAT = sdp_pkg::CAS_LATENCY,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic memory_output_clock_o,
  output logic space_chip_enable_n_o,
  output logic row_addr_strobe_n_o,
  output logic col_addr_strobe_n_o,
  output logic sdram_write_enable_n_o,
  output logic [ADDR_W-1:0] sdram_addr_o,
  output logic [BANK_W-1:0] sdram_bank_o,
  output logic [DATA_W/8-1:0] byte_enable_n_o,
  input wire logic [DATA_W-1:0] sdram_dq_i,
  output logic [DATA_W-1:0] sdram_dq_o,
  output logic sdram_dq_oe_o,
  output logic sdram_clock_enable_out_o,
  output logic sdram_clock_enable_oe_o,
  output logic direct_transfer_strobe_o
);
  initial begin
    if (DATA_W > 32 || DATA_W < 8 || DATA_W % 8 != 0) begin
      $error("sdp_port: DATA_W must be 8, 16, 24 or 32");
    end
    if (CAS_LAT < 2 || CAS_LAT > 3 || ADDR_W <= sdp_pkg::AUTO_PRE_BIT) begin
      $error("sdp_port: CAS_LAT must be 2 or 3 and ADDR_W must exceed 10");
    end
    if (ADDR_W + BANK_W > 32) begin
      $error("sdp_port: address and bank do not fit one word");
    end
  end

  localparam logic [3:0] CAS_CYC = 4'(CAS_LAT);

  sdp_pkg::sdp_state_t state_q;
  sdp_pkg::sdp_op_t op_q;
  logic [3:0] ctrl_q;
  logic [ADDR_W+BANK_W-1:0] addr_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [31:0] prdata_q;
  logic [3:0] cyc_q;
  logic pend_q;
  logic xdir_q;
  logic refused_q;
  logic sref_q;
  logic mclk_q;
  logic rise_en;
  logic busy;
  logic acc_phase;
  logic hit_cmd;
  logic hit_wdata;
  logic hit_status;
  logic mapped;
  logic cmd_legal;
  logic cmd_take;
  logic issue;
  logic [3:0] cyc_n;
  logic [3:0] last_cyc;
  logic [3:0] strobe_cyc;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [31:0] fifo_out_data;
  sdp_pkg::sdp_op_t new_op;
  logic [1:0] rd_lat;
  logic [1:0] wr_lat;

  assign rd_lat = ctrl_q[sdp_pkg::CTRL_RD_LAT_LSB +: 2];
  assign wr_lat = ctrl_q[sdp_pkg::CTRL_WR_LAT_LSB +: 2];

  // Memory clock runs at half the core rate; outputs move only when it rises
  assign rise_en = !mclk_q;
  assign memory_output_clock_o = mclk_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mclk_q <= 1'b0;
    end else begin
      mclk_q <= !mclk_q;
    end
  end

  // Data pins come from another timing domain
  always_ff @(posedge core_clk_i) begin
    dq_s1_q <= sdram_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // APB decode; a full write buffer stalls the bus rather than drop data
  assign acc_phase = psel_i && penable_i;
  assign hit_cmd = paddr_i == sdp_pkg::REG_CMD;
  assign hit_wdata = paddr_i == sdp_pkg::REG_WDATA;
  assign hit_status = paddr_i == sdp_pkg::REG_STATUS;
  assign mapped = (paddr_i == sdp_pkg::REG_CTRL) || hit_cmd || hit_status
      || (paddr_i == sdp_pkg::REG_ADDR) || hit_wdata || (paddr_i == sdp_pkg::REG_RDATA);
  assign pready_o = !(hit_wdata && pwrite_i && !fifo_in_ready);
  assign pslverr_o = acc_phase && !mapped;
  assign prdata_o = prdata_q;

  assign new_op = sdp_pkg::sdp_op_t'(pwdata_i[sdp_pkg::CMD_OP_LSB +: 3]);
  assign busy = pend_q || (state_q == sdp_pkg::ST_BUSY);
  always_comb begin
    cmd_legal = !busy;
    if (sref_q) begin
      cmd_legal = !busy && (new_op == sdp_pkg::OP_SREF_EXIT);
    end else if (new_op == sdp_pkg::OP_SREF_EXIT) begin
      cmd_legal = 1'b0;
    end else if (new_op == sdp_pkg::OP_SREF_ENTER) begin
      cmd_legal = !busy && WIDE_PORT;
    end
  end
  assign cmd_take = acc_phase && pwrite_i && hit_cmd && cmd_legal;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr_i)
        sdp_pkg::REG_CTRL: prdata_q[3:0] <= ctrl_q;
        sdp_pkg::REG_CMD: prdata_q <= 32'({xdir_q, op_q});
        sdp_pkg::REG_STATUS: prdata_q[3:0] <= {!fifo_in_ready, sref_q, refused_q, busy};
        sdp_pkg::REG_ADDR: prdata_q <= 32'(addr_q);
        sdp_pkg::REG_RDATA: prdata_q <= 32'(rdata_q);
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= sdp_pkg::CTRL_RESET;
      addr_q <= '0;
    end else if (acc_phase && pwrite_i) begin
      if (paddr_i == sdp_pkg::REG_CTRL) begin
        ctrl_q <= pwdata_i[3:0];
      end
      if (paddr_i == sdp_pkg::REG_ADDR) begin
        addr_q <= pwdata_i[ADDR_W+BANK_W-1:0];
      end
    end
  end

  // Refused commands leave a sticky flag; a new refusal beats the clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      refused_q <= 1'b0;
    end else if (acc_phase && pwrite_i && hit_cmd && !cmd_legal) begin
      refused_q <= 1'b1;
    end else if (acc_phase && pwrite_i && hit_status && pwdata_i[sdp_pkg::STAT_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // A direct transfer only counts when the option for its direction is set
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      op_q <= sdp_pkg::OP_NOP;
      xdir_q <= 1'b0;
    end else if (cmd_take) begin
      op_q <= new_op;
      xdir_q <= pwdata_i[sdp_pkg::CMD_DIRECT_BIT]
          && (((new_op == sdp_pkg::OP_READ) && pwdata_i[sdp_pkg::CMD_SRC_OPT_BIT])
          || ((new_op == sdp_pkg::OP_WRITE) && pwdata_i[sdp_pkg::CMD_DST_OPT_BIT]));
    end
  end

  sdp_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(acc_phase && pwrite_i && hit_wdata),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pwdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // A buffered write waits for its data; a direct write never touches the buffer
  assign issue = rise_en && pend_q && (state_q == sdp_pkg::ST_IDLE)
      && !((op_q == sdp_pkg::OP_WRITE) && !xdir_q && !fifo_out_valid);
  assign fifo_pop = issue && (op_q == sdp_pkg::OP_WRITE) && !xdir_q;

  assign cyc_n = cyc_q + 4'h1;
  assign strobe_cyc = (op_q == sdp_pkg::OP_READ) ? CAS_CYC + 4'(rd_lat) : 4'(wr_lat);
  always_comb begin
    last_cyc = 4'h0;
    if (op_q == sdp_pkg::OP_READ) begin
      last_cyc = xdir_q ? strobe_cyc : CAS_CYC;
    end else if (op_q == sdp_pkg::OP_WRITE && xdir_q) begin
      last_cyc = strobe_cyc;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= sdp_pkg::ST_IDLE;
      pend_q <= 1'b0;
      cyc_q <= 4'h0;
    end else begin
      if (cmd_take) begin
        pend_q <= 1'b1;
      end
      if (issue) begin
        pend_q <= 1'b0;
        cyc_q <= 4'h0;
        state_q <= sdp_pkg::ST_BUSY;
      end else if (rise_en && state_q == sdp_pkg::ST_BUSY) begin
        cyc_q <= cyc_n;
        if (cyc_n > last_cyc) begin
          state_q <= sdp_pkg::ST_IDLE;
        end
      end
    end
  end

  // Command pins; everything here changes with the memory clock rise
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      space_chip_enable_n_o <= 1'b1;
      {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_NOP;
      sdram_addr_o <= '0;
      sdram_bank_o <= '0;
      byte_enable_n_o <= '1;
    end else if (rise_en) begin
      space_chip_enable_n_o <= 1'b1;
      {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_NOP;
      byte_enable_n_o <= '1;
      if (issue) begin
        space_chip_enable_n_o <= (op_q == sdp_pkg::OP_SREF_EXIT) || (op_q == sdp_pkg::OP_NOP);
        sdram_addr_o <= addr_q[ADDR_W-1:0];
        sdram_bank_o <= addr_q[ADDR_W +: BANK_W];
        unique case (op_q)
          sdp_pkg::OP_NOP, sdp_pkg::OP_SREF_EXIT: begin
            {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_NOP;
          end
          sdp_pkg::OP_ACTIVATE: begin
            {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_ACTIVATE;
          end
          sdp_pkg::OP_READ, sdp_pkg::OP_WRITE: begin
            {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <=
                (op_q == sdp_pkg::OP_READ) ? sdp_pkg::SIG_READ : sdp_pkg::SIG_WRITE;
            sdram_addr_o[sdp_pkg::AUTO_PRE_BIT] <= 1'b0;
            byte_enable_n_o <= '0;
          end
          sdp_pkg::OP_DEACT_BANK, sdp_pkg::OP_DEACT_ALL: begin
            {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_DEACT;
            sdram_addr_o[sdp_pkg::AUTO_PRE_BIT] <= op_q == sdp_pkg::OP_DEACT_ALL;
          end
          sdp_pkg::OP_SREF_ENTER: begin
            {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} <= sdp_pkg::SIG_SREF;
          end
        endcase
      end else if (state_q == sdp_pkg::ST_BUSY && op_q == sdp_pkg::OP_READ && cyc_n <= CAS_CYC) begin
        byte_enable_n_o <= '0;
      end
    end
  end

  // Write data bus; a direct write leaves it to the peripheral
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sdram_dq_o <= '0;
      sdram_dq_oe_o <= 1'b0;
    end else if (rise_en) begin
      sdram_dq_oe_o <= fifo_pop;
      if (fifo_pop) begin
        sdram_dq_o <= fifo_out_data[DATA_W-1:0];
      end
    end
  end

  // Read capture; data is taken from the synchroniser at the data phase rise
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else if (rise_en && state_q == sdp_pkg::ST_BUSY && op_q == sdp_pkg::OP_READ
        && !xdir_q && cyc_n == CAS_CYC) begin
      rdata_q <= dq_s2_q;
    end
  end

  // Strobe goes high for one memory clock at data phase plus latency
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      direct_transfer_strobe_o <= 1'b0;
    end else if (rise_en) begin
      direct_transfer_strobe_o <= 1'b0;
      if (issue) begin
        direct_transfer_strobe_o <= xdir_q && op_q == sdp_pkg::OP_WRITE && wr_lat == 2'h0;
      end else if (state_q == sdp_pkg::ST_BUSY) begin
        direct_transfer_strobe_o <= xdir_q && cyc_n == strobe_cyc;
      end
    end
  end

  // Clock enable exists on the wide port only; it drops solely in self-refresh
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sref_q <= 1'b0;
    end else if (issue && WIDE_PORT) begin
      if (op_q == sdp_pkg::OP_SREF_ENTER) begin
        sref_q <= 1'b1;
      end else if (op_q == sdp_pkg::OP_SREF_EXIT) begin
        sref_q <= 1'b0;
      end
    end
  end
  assign sdram_clock_enable_out_o = !sref_q;
  assign sdram_clock_enable_oe_o = WIDE_PORT;

  chk_strobe_read_opt: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(direct_transfer_strobe_o) && op_q == sdp_pkg::OP_READ |-> xdir_q)
    else $error("strobe on read without source option");
  chk_strobe_write_opt: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(direct_transfer_strobe_o) |-> xdir_q && op_q inside {sdp_pkg::OP_READ, sdp_pkg::OP_WRITE})
    else $error("strobe outside a direct transfer");
  chk_direct_no_capture: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state_q == sdp_pkg::ST_BUSY && xdir_q |=> $stable(rdata_q))
    else $error("read data captured in direct transfer");
  chk_direct_bus_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
    op_q == sdp_pkg::OP_WRITE && xdir_q && (busy || $past(busy)) |-> !sdram_dq_oe_o)
    else $error("data bus driven in direct write");
  chk_read_strobe_lat: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(direct_transfer_strobe_o) && op_q == sdp_pkg::OP_READ
      |-> cyc_q == CAS_CYC + 4'(rd_lat) ##1 direct_transfer_strobe_o ##1 !direct_transfer_strobe_o)
    else $error("read strobe latency wrong");
  chk_write_strobe_lat: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(direct_transfer_strobe_o) && op_q == sdp_pkg::OP_WRITE
      |-> (state_q == sdp_pkg::ST_BUSY) && cyc_q == 4'(wr_lat))
    else $error("write strobe latency wrong");
  chk_cke_wide_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !sdram_clock_enable_out_o |-> WIDE_PORT && sref_q)
    else $error("clock enable low outside wide self-refresh");
  chk_deact_encode: assert property (@(posedge core_clk_i) disable iff (reset_i)
    issue && op_q inside {sdp_pkg::OP_DEACT_BANK, sdp_pkg::OP_DEACT_ALL} |=> !space_chip_enable_n_o
      && {row_addr_strobe_n_o, col_addr_strobe_n_o, sdram_write_enable_n_o} == sdp_pkg::SIG_DEACT
      && sdram_addr_o[sdp_pkg::AUTO_PRE_BIT] == (op_q == sdp_pkg::OP_DEACT_ALL))
    else $error("deactivate encoding wrong");
  chk_cmd_encode: assert property (@(posedge core_clk_i) disable iff (reset_i)
    issue && op_q == sdp_pkg::OP_READ |=> !space_chip_enable_n_o && !col_addr_strobe_n_o
      && row_addr_strobe_n_o && sdram_write_enable_n_o ##2 space_chip_enable_n_o)
    else $error("read command encoding wrong");
  chk_edge_aligned: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !$stable({space_chip_enable_n_o, row_addr_strobe_n_o, col_addr_strobe_n_o,
      sdram_write_enable_n_o, sdram_addr_o, sdram_dq_o, direct_transfer_strobe_o})
      |-> memory_output_clock_o)
    else $error("pin change off the memory clock rise");
  chk_sref_narrow: assert property (@(posedge core_clk_i) disable iff (reset_i)
    acc_phase && pwrite_i && hit_cmd && !WIDE_PORT && new_op == sdp_pkg::OP_SREF_ENTER
      |=> refused_q && !sref_q)
    else $error("self-refresh taken on narrow port");
  chk_strobe_pins: assert property (@(posedge core_clk_i) disable iff (reset_i)
    issue && op_q == sdp_pkg::OP_ACTIVATE |=> !row_addr_strobe_n_o && col_addr_strobe_n_o
      && sdram_write_enable_n_o)
    else $error("activate not on row strobe");

endmodule : sdp_port

// [src/sdp_pkg.sv]
package sdp_pkg;

  // Core clock and timing
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned CAS_LATENCY = 3;

  // APB register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0C;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_RD_LAT_LSB = 0;
  localparam int unsigned CTRL_WR_LAT_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_DIRECT_BIT = 3;
  localparam int unsigned CMD_SRC_OPT_BIT = 4;
  localparam int unsigned CMD_DST_OPT_BIT = 5;

  // Status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_REFUSED_BIT = 1;
  localparam int unsigned STAT_SREF_BIT = 2;
  localparam int unsigned STAT_FULL_BIT = 3;

  // Address register: bank sits just above the address bits
  localparam int unsigned AUTO_PRE_BIT = 10;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACTIVATE = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_DEACT_BANK = 3'h4,
    OP_DEACT_ALL = 3'h5,
    OP_SREF_ENTER = 3'h6,
    OP_SREF_EXIT = 3'h7
  } sdp_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } sdp_state_t;

  // Strobe codes as {row, column, write enable}, active low
  localparam logic [2:0] SIG_NOP = 3'h7;
  localparam logic [2:0] SIG_ACTIVATE = 3'h3;
  localparam logic [2:0] SIG_READ = 3'h5;
  localparam logic [2:0] SIG_WRITE = 3'h4;
  localparam logic [2:0] SIG_DEACT = 3'h2;
  localparam logic [2:0] SIG_SREF = 3'h1;

endpackage : sdp_pkg

// [src/sdp_fifo.sv]
`timescale 1ns/10ps
module sdp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sdp_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty without a counter
  assign out_valid_o = wr_ptr_q != rd_ptr_q;
  assign in_ready_o = (wr_ptr_q[AW] == rd_ptr_q[AW]) || (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : sdp_fifo

// [dv/sdp_sdram_model.sv]
`timescale 1ns/10ps
module sdp_sdram_model #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned CAS_LAT = 3
) (
  input wire logic core_clk_i,
  input wire logic mclk_i,
  input wire logic cs_n_i,
  input wire logic [2:0] cmd_i,
  input wire logic [14:0] key_i,
  input wire logic dq_oe_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rd_q;
  int cnt;

  initial begin
    cnt = 0;
    rd_q = '0;
    dq_o = '0;
  end

  // Data only inside the CAS window; elsewhere the bus toggles so stale data never matches
  always @(posedge core_clk_i) begin
    if (mclk_i === 1'b1) begin
      if (cnt != 0) cnt++;
      if (cs_n_i === 1'b0 && cmd_i === sdp_pkg::SIG_READ) begin
        cnt = 1;
        rd_q = mem.exists(key_i) ? mem[key_i] : '1;
      end
      if (cs_n_i === 1'b0 && cmd_i === sdp_pkg::SIG_WRITE && dq_oe_i === 1'b1) mem[key_i] = dq_i;
      dq_o <= (cnt != 0 && cnt + 2 >= int'(CAS_LAT) && cnt <= int'(CAS_LAT)) ? rd_q : ~dq_o;
    end
  end
endmodule : sdp_sdram_model

// [dv/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clk, rst, psel, pen, pwr, perr, err_q, prdy, mclk, cs_n, ras_n, cas_n, we_n;
  logic oe, cke, cke_oe, direct_transfer_strobe, a10, n_cke, n_cke_oe;
  logic [7:0] pa;
  logic [31:0] pwd, prd, r;
  logic [12:0] sa;
  logic [1:0] sb, be_n;
  logic [15:0] dqi, dqo;
  logic [2:0] last_cmd;
  int mismatches, checked, mrise, cmd_at, pdt_at, pdt_n, oe_n, cyc;
  logic [2:0] ops [3] = '{sdp_pkg::OP_ACTIVATE, sdp_pkg::OP_DEACT_BANK, sdp_pkg::OP_DEACT_ALL};
  logic [2:0] sig [3] = '{sdp_pkg::SIG_ACTIVATE, sdp_pkg::SIG_DEACT, sdp_pkg::SIG_DEACT};

  sdp_port dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .memory_output_clock_o(mclk), .space_chip_enable_n_o(cs_n), .row_addr_strobe_n_o(ras_n),
    .col_addr_strobe_n_o(cas_n), .sdram_write_enable_n_o(we_n), .sdram_addr_o(sa),
    .sdram_bank_o(sb), .byte_enable_n_o(be_n), .sdram_dq_i(dqi), .sdram_dq_o(dqo),
    .sdram_dq_oe_o(oe), .sdram_clock_enable_out_o(cke), .sdram_clock_enable_oe_o(cke_oe),
    .direct_transfer_strobe_o(direct_transfer_strobe));
  // Narrow port sees the same bus traffic; only its clock enable and refusals matter
  sdp_port #(.WIDE_PORT(1'b0)) narrow (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(), .pready_o(),
    .pslverr_o(), .memory_output_clock_o(), .space_chip_enable_n_o(), .row_addr_strobe_n_o(),
    .col_addr_strobe_n_o(), .sdram_write_enable_n_o(), .sdram_addr_o(), .sdram_bank_o(),
    .byte_enable_n_o(), .sdram_dq_i(dqi), .sdram_dq_o(), .sdram_dq_oe_o(),
    .sdram_clock_enable_out_o(n_cke), .sdram_clock_enable_oe_o(n_cke_oe),
    .direct_transfer_strobe_o());
  sdp_sdram_model partner (.core_clk_i(clk), .mclk_i(mclk), .cs_n_i(cs_n),
    .cmd_i({ras_n, cas_n, we_n}), .key_i({sb, sa}), .dq_oe_i(oe), .dq_i(dqo), .dq_o(dqi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out;
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    r = prd;
    err_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Option bits are {dest, source, direct}; bank fixed at 1
  task automatic cmd(input logic [2:0] op, input logic [2:0] opt, input logic [12:0] a);
    apb(1'b1, sdp_pkg::REG_ADDR, {17'h0, 2'h1, a});
    apb(1'b1, sdp_pkg::REG_CMD, {26'h0, opt, op});
    repeat (2) @(posedge clk);
    apb(1'b0, sdp_pkg::REG_STATUS, 32'h0);
    for (int k = 0; k < 40 && r[0] !== 1'b0; k++) apb(1'b0, sdp_pkg::REG_STATUS, 32'h0);
  endtask : cmd

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // Pins are read before this edge's updates, i.e. what the memory saw at the rise
  always @(posedge clk) begin
    if (rst === 1'b0 && mclk === 1'b1) begin
      mrise++;
      if (cs_n === 1'b0) begin
        last_cmd = {ras_n, cas_n, we_n};
        a10 = sa[10];
        cmd_at = mrise;
      end
      if (direct_transfer_strobe === 1'b1) begin
        pdt_at = mrise;
        pdt_n++;
      end
      if (oe === 1'b1) oe_n++;
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 8'h00;
    pwd = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(cke, 1'b1);
    chk(cke_oe, 1'b1);
    chk(n_cke_oe, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk({r[30:0], err_q}, 32'h1);
    for (int i = 0; i < 8; i++) apb(1'b1, sdp_pkg::REG_WDATA, 32'hA000 + i);
    apb(1'b0, sdp_pkg::REG_STATUS, 32'h0);
    chk(r[3], 1'b1);
    for (int i = 0; i < 8; i++) begin
      cmd(sdp_pkg::OP_WRITE, 3'h0, 13'(i));
      chk(last_cmd, sdp_pkg::SIG_WRITE);
    end
    chk(oe_n, 8);
    for (int i = 0; i < 8; i++) begin
      cmd(sdp_pkg::OP_READ, 3'h0, 13'(i));
      apb(1'b0, sdp_pkg::REG_RDATA, 32'h0);
      chk({last_cmd, r[28:0]}, {sdp_pkg::SIG_READ, 29'hA000 + 29'(i)});
    end
    chk(pdt_n, 0);
    for (int i = 0; i < 3; i++) begin
      cmd(ops[i], 3'h0, 13'h0);
      chk({last_cmd, a10}, {sig[i], i == 2});
    end
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, sdp_pkg::REG_CTRL, 32'(l));
      cmd(sdp_pkg::OP_READ, 3'b011, 13'h0);
      chk(pdt_at - cmd_at, sdp_pkg::CAS_LATENCY + l);
    end
    apb(1'b0, sdp_pkg::REG_RDATA, 32'h0);
    chk(r, 32'hA007);
    // Direct bit with the wrong option is an ordinary read
    cmd(sdp_pkg::OP_READ, 3'b101, 13'h0);
    apb(1'b0, sdp_pkg::REG_RDATA, 32'h0);
    chk(pdt_n, 32'd4);
    chk(r, 32'hA000);
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, sdp_pkg::REG_CTRL, 32'(l) << 2);
      cmd(sdp_pkg::OP_WRITE, 3'b101, 13'h5);
      chk(pdt_at - cmd_at, l);
    end
    chk(oe_n, 8);
    apb(1'b1, sdp_pkg::REG_WDATA, 32'h5A5A);
    cmd(sdp_pkg::OP_WRITE, 3'b011, 13'h5);
    cmd(sdp_pkg::OP_READ, 3'h0, 13'h5);
    apb(1'b0, sdp_pkg::REG_RDATA, 32'h0);
    chk(pdt_n, 32'd8);
    chk(r, 32'h5A5A);
    cmd(sdp_pkg::OP_SREF_ENTER, 3'h0, 13'h0);
    chk({cke, last_cmd}, {1'b0, sdp_pkg::SIG_SREF});
    chk(n_cke, 1'b1);
    apb(1'b1, sdp_pkg::REG_CMD, 32'(sdp_pkg::OP_READ));
    apb(1'b0, sdp_pkg::REG_STATUS, 32'h0);
    chk(r[2:1], 2'h3);
    cmd(sdp_pkg::OP_SREF_EXIT, 3'h0, 13'h0);
    chk(cke, 1'b1);
    close_out();
  end
endmodule : testbench
